// file: common/pin_irq_consts.svh
// Purpose: offsets, field positions and reset values of the pin/low-voltage interrupt block
// Assumes: 8-bit register port, byte offsets as printed
// Notes: included by its bare name
`ifndef PIN_IRQ_CONSTS_SVH
`define PIN_IRQ_CONSTS_SVH

`define OFS_EXT_ENABLE_GROUP 8'h84
`define OFS_EXT_EDGE_FLAGS 8'h85
`define OFS_TIMER_EXT_CTRL 8'h88
`define OFS_SHARED_FLAGS 8'h95
`define OFS_PORT_WAKE_EN 8'h96
`define OFS_INT_ENABLE_MAIN 8'ha8
`define OFS_INT_ENABLE_EXTRA 8'ha9
`define OFS_LOW_VOLT_CTRL 8'hbf

// timer_and_ext_control fields
`define BIT_TRIGGER_TYPE_A 0
`define BIT_STD_FLAG_A 1
`define BIT_TRIGGER_TYPE_B 2
`define BIT_STD_FLAG_B 3
// shared_interrupt_flags fields
`define BIT_PORT_CHANGE_FLAG 1
`define BIT_LOW_VOLTAGE_FLAG 7
// interrupt_enable_main fields
`define BIT_STD_ENABLE_A 0
`define BIT_STD_ENABLE_B 2
`define BIT_GLOBAL_INT_ENABLE 7
// interrupt_enable_extra fields
`define BIT_PORT_CHANGE_INT_EN 1
`define BIT_GROUP_LOWVOLT_EN 2
// low voltage control fields
`define BIT_LOW_VOLTAGE_ENABLE 7

`define RST_BYTE 8'h00
`define MASK_MAIN_ENABLE 8'hbf
`define MASK_SHARED_FLAGS 8'h82

`endif

// file: common/pin_irq_pkg.sv
// Purpose: types shared by the pin/low-voltage interrupt block
// Assumes: nothing
// Notes: constants live in pin_irq_consts.svh
package pin_irq_pkg;
  typedef logic [7:0] byte_t;
  // service acknowledge codes from the core
  typedef enum logic [1:0] {
    ACK_NONE = 2'b00,
    ACK_STD_A = 2'b01,
    ACK_STD_B = 2'b10,
    ACK_PORT = 2'b11
  } ack_t;
endpackage

// file: src/pin_irq_wakeup.sv
// Purpose: external pin, port-change and low-voltage interrupt flags, gating and wake-up
// Assumes: pins synchronous to CLK_SYS_IN; core acks service entry with a one-cycle pulse
// Notes: registers reached over a plain strobe port, read data one cycle after read strobe
//
// Function
// - std inputs: level when type 0, edge when 1
// - extra inputs trigger on falling edge only
// - port change interrupt on any enabled pin toggle
// - block stop/halt entry while enabled input low
// - extra enables gate interrupt and wake-up
// - extra request needs own and group enable
// - extra edge flags set regardless of enable
// - extra flags cleared only by writing zero
// - std flags set on fall, cleared at service
// - low-voltage flag hardware set, cleared by write
// - port flag set by wake-enabled pin change
// - port flag auto-cleared at service or written
// - shared flags: zero clears, one keeps
// - eight port wake enables, reset to zero
// - global enable blocks all interrupts when zero
// - std enables gate interrupt and wake-up
// - group enable covers extras and low voltage
// - low supply detector raises low-voltage request
// - low-voltage needs own and group enable
// - service entry needs global and port enable
`include "pin_irq_consts.svh"

module pin_irq_wakeup (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  // register port
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  // pins
  input wire logic STD_EXT_INPUT_A_IN,
  input wire logic STD_EXT_INPUT_B_IN,
  input wire logic [7:0] EXTRA_EXT_INPUTS_IN,
  input wire logic [7:0] PORT_PINS_IN,
  input wire logic LOW_VOLTAGE_DETECT_IN,
  // core side
  input wire logic [1:0] SERVICE_ACK_IN,
  output logic STD_A_REQ_OUT,
  output logic STD_B_REQ_OUT,
  output logic EXTRA_REQ_OUT,
  output logic PORT_CHANGE_REQ_OUT,
  output logic LOW_VOLTAGE_REQ_OUT,
  output logic WAKE_OUT,
  output logic STOP_BLOCK_OUT
);

  pin_irq_pkg::byte_t enable_group_reg;
  pin_irq_pkg::byte_t edge_flags_reg;
  pin_irq_pkg::byte_t ctrl_reg;
  pin_irq_pkg::byte_t port_wake_en_reg;
  pin_irq_pkg::byte_t enable_main_reg;
  pin_irq_pkg::byte_t enable_extra_reg;
  logic low_voltage_enable_reg;
  logic port_flag_reg;
  logic low_voltage_flag_reg;
  // input sampling stages
  logic std_a_s_reg;
  logic std_a_d_reg;
  logic std_b_s_reg;
  logic std_b_d_reg;
  pin_irq_pkg::byte_t extra_s_reg;
  pin_irq_pkg::byte_t extra_d_reg;
  pin_irq_pkg::byte_t port_s_reg;
  pin_irq_pkg::byte_t port_d_reg;
  logic lowv_s_reg;

  logic std_a_fall;
  logic std_b_fall;
  pin_irq_pkg::byte_t extra_fall;
  logic port_change;
  logic ack_a;
  logic ack_b;
  logic ack_port;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_shared;
  logic global_en;
  logic group_en;
  logic std_en_a;
  logic std_en_b;
  logic level_a;
  logic level_b;
  pin_irq_pkg::byte_t extra_armed;
  pin_irq_pkg::byte_t rdata_next;

  // std input a: two sample stages, the second doubles as the edge reference
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      std_a_s_reg <= 1'b1;
      std_a_d_reg <= 1'b1;
    end else begin
      std_a_s_reg <= STD_EXT_INPUT_A_IN;
      std_a_d_reg <= std_a_s_reg;
    end
  end

  // std input b: reset to the idle high level so release shows no false fall
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      std_b_s_reg <= 1'b1;
      std_b_d_reg <= 1'b1;
    end else begin
      std_b_s_reg <= STD_EXT_INPUT_B_IN;
      std_b_d_reg <= std_b_s_reg;
    end
  end

  // extra inputs: same scheme, all eight idle high
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      extra_s_reg <= 8'hff;
      extra_d_reg <= 8'hff;
    end else begin
      extra_s_reg <= EXTRA_EXT_INPUTS_IN;
      extra_d_reg <= extra_s_reg;
    end
  end

  // port pins: reset low; a pin already high shows one change once sampled
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      port_s_reg <= `RST_BYTE;
      port_d_reg <= `RST_BYTE;
    end else begin
      port_s_reg <= PORT_PINS_IN;
      port_d_reg <= port_s_reg;
    end
  end

  // supply detector: a level, so one stage is enough
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      lowv_s_reg <= 1'b0;
    end else begin
      lowv_s_reg <= LOW_VOLTAGE_DETECT_IN;
    end
  end

  // edge detection against the previous sample; pins are synchronous so no extra stage
  assign std_a_fall = std_a_d_reg & ~std_a_s_reg;
  assign std_b_fall = std_b_d_reg & ~std_b_s_reg;
  assign extra_fall = extra_d_reg & ~extra_s_reg;
  // port pins captured at reset as zero, so a pin high from reset shows one change
  assign port_change = |((port_d_reg ^ port_s_reg) & port_wake_en_reg);

  // service acknowledge decode and write strobes
  assign ack_a = (SERVICE_ACK_IN == pin_irq_pkg::ACK_STD_A);
  assign ack_b = (SERVICE_ACK_IN == pin_irq_pkg::ACK_STD_B);
  assign ack_port = (SERVICE_ACK_IN == pin_irq_pkg::ACK_PORT);
  assign wr_ctrl = WR_IN && (ADDR_IN == `OFS_TIMER_EXT_CTRL);
  assign wr_flags = WR_IN && (ADDR_IN == `OFS_EXT_EDGE_FLAGS);
  assign wr_shared = WR_IN && (ADDR_IN == `OFS_SHARED_FLAGS);

  // per-input enables of the extra inputs
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      enable_group_reg <= `RST_BYTE;
    end else if (WR_IN && (ADDR_IN == `OFS_EXT_ENABLE_GROUP)) begin
      enable_group_reg <= WDATA_IN;
    end
  end

  // per-pin port wake enables
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      port_wake_en_reg <= `RST_BYTE;
    end else if (WR_IN && (ADDR_IN == `OFS_PORT_WAKE_EN)) begin
      port_wake_en_reg <= WDATA_IN;
    end
  end

  // main enables; the reserved bit is masked so it always reads zero
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      enable_main_reg <= `RST_BYTE;
    end else if (WR_IN && (ADDR_IN == `OFS_INT_ENABLE_MAIN)) begin
      enable_main_reg <= WDATA_IN & `MASK_MAIN_ENABLE;
    end
  end

  // extra enables: group enable and port change interrupt enable
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      enable_extra_reg <= `RST_BYTE;
    end else if (WR_IN && (ADDR_IN == `OFS_INT_ENABLE_EXTRA)) begin
      enable_extra_reg <= WDATA_IN;
    end
  end

  // low-voltage enable; threshold selection lives outside this block
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      low_voltage_enable_reg <= 1'b0;
    end else if (WR_IN && (ADDR_IN == `OFS_LOW_VOLT_CTRL)) begin
      low_voltage_enable_reg <= WDATA_IN[`BIT_LOW_VOLTAGE_ENABLE];
    end
  end

  // control register: trigger types and std flags; hardware set beats clear
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ctrl_reg <= `RST_BYTE;
    end else begin
      ctrl_reg <= wr_ctrl ? WDATA_IN : ctrl_reg;
      // flag follows the falling edge in either mode; level mode takes its request from the low pin instead
      if (std_a_fall) begin
        ctrl_reg[`BIT_STD_FLAG_A] <= 1'b1;
      end else if (ack_a) begin
        ctrl_reg[`BIT_STD_FLAG_A] <= 1'b0;
      end else if (wr_ctrl) begin
        ctrl_reg[`BIT_STD_FLAG_A] <= WDATA_IN[`BIT_STD_FLAG_A];
      end
      if (std_b_fall) begin
        ctrl_reg[`BIT_STD_FLAG_B] <= 1'b1;
      end else if (ack_b) begin
        ctrl_reg[`BIT_STD_FLAG_B] <= 1'b0;
      end else if (wr_ctrl) begin
        ctrl_reg[`BIT_STD_FLAG_B] <= WDATA_IN[`BIT_STD_FLAG_B];
      end
    end
  end

  // extra edge flags: one per input, set on fall, only a written zero clears
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_extra
      always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
          edge_flags_reg[i] <= 1'b0;
        end else if (extra_fall[i]) begin
          edge_flags_reg[i] <= 1'b1;
        end else if (wr_flags && !WDATA_IN[i]) begin
          edge_flags_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // port change flag: written zero or service entry clears; a new change wins
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      port_flag_reg <= 1'b0;
    end else if (port_change) begin
      port_flag_reg <= 1'b1;
    end else if (ack_port || (wr_shared && !WDATA_IN[`BIT_PORT_CHANGE_FLAG])) begin
      port_flag_reg <= 1'b0;
    end
  end

  // low-voltage flag re-sets every cycle the detector stays high, so a clear
  // only sticks once the supply has recovered
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      low_voltage_flag_reg <= 1'b0;
    end else if (lowv_s_reg) begin
      low_voltage_flag_reg <= 1'b1;
    end else if (wr_shared && !WDATA_IN[`BIT_LOW_VOLTAGE_FLAG]) begin
      low_voltage_flag_reg <= 1'b0;
    end
  end

  // enable decode
  assign global_en = enable_main_reg[`BIT_GLOBAL_INT_ENABLE];
  assign group_en = enable_extra_reg[`BIT_GROUP_LOWVOLT_EN];
  assign std_en_a = enable_main_reg[`BIT_STD_ENABLE_A];
  assign std_en_b = enable_main_reg[`BIT_STD_ENABLE_B];
  // level mode request is the low pin itself, edge mode the latched flag
  assign level_a = ctrl_reg[`BIT_TRIGGER_TYPE_A] ? ctrl_reg[`BIT_STD_FLAG_A] : ~std_a_s_reg;
  assign level_b = ctrl_reg[`BIT_TRIGGER_TYPE_B] ? ctrl_reg[`BIT_STD_FLAG_B] : ~std_b_s_reg;
  assign extra_armed = edge_flags_reg & enable_group_reg & {8{group_en}};

  // std a request; registered so the core never sees a decode glitch
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      STD_A_REQ_OUT <= 1'b0;
    end else begin
      STD_A_REQ_OUT <= global_en & std_en_a & level_a;
    end
  end

  // std b request
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      STD_B_REQ_OUT <= 1'b0;
    end else begin
      STD_B_REQ_OUT <= global_en & std_en_b & level_b;
    end
  end

  // one shared request for all eight extra inputs; software reads the flags
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      EXTRA_REQ_OUT <= 1'b0;
    end else begin
      EXTRA_REQ_OUT <= global_en & (|extra_armed);
    end
  end

  // port change request needs its own interrupt enable on top of the flag
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      PORT_CHANGE_REQ_OUT <= 1'b0;
    end else begin
      PORT_CHANGE_REQ_OUT <= global_en & enable_extra_reg[`BIT_PORT_CHANGE_INT_EN]
                             & port_flag_reg;
    end
  end

  // low-voltage request: global, group and dedicated enable all needed
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      LOW_VOLTAGE_REQ_OUT <= 1'b0;
    end else begin
      LOW_VOLTAGE_REQ_OUT <= global_en & group_en & low_voltage_enable_reg
                             & low_voltage_flag_reg;
    end
  end

  // wake-up ignores the global enable; port enable does not gate wake either
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      WAKE_OUT <= 1'b0;
    end else begin
      WAKE_OUT <= (std_en_a & level_a) | (std_en_b & level_b) | (|extra_armed)
                  | port_flag_reg;
    end
  end

  // a low enabled pin would wake the core at once, so entry is refused;
  // uses the sampled level, so a pin must stay low a clock to count
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      STOP_BLOCK_OUT <= 1'b0;
    end else begin
      STOP_BLOCK_OUT <= (std_en_a & ~std_a_s_reg) | (std_en_b & ~std_b_s_reg)
                        | (group_en & |(enable_group_reg & ~extra_s_reg));
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = `RST_BYTE;
    if (ADDR_IN == `OFS_EXT_ENABLE_GROUP) begin
      rdata_next = enable_group_reg;
    end else if (ADDR_IN == `OFS_EXT_EDGE_FLAGS) begin
      rdata_next = edge_flags_reg;
    end else if (ADDR_IN == `OFS_TIMER_EXT_CTRL) begin
      rdata_next = ctrl_reg;
    end else if (ADDR_IN == `OFS_SHARED_FLAGS) begin
      rdata_next[`BIT_PORT_CHANGE_FLAG] = port_flag_reg;
      rdata_next[`BIT_LOW_VOLTAGE_FLAG] = low_voltage_flag_reg;
    end else if (ADDR_IN == `OFS_PORT_WAKE_EN) begin
      rdata_next = port_wake_en_reg;
    end else if (ADDR_IN == `OFS_INT_ENABLE_MAIN) begin
      rdata_next = enable_main_reg;
    end else if (ADDR_IN == `OFS_INT_ENABLE_EXTRA) begin
      rdata_next = enable_extra_reg;
    end else if (ADDR_IN == `OFS_LOW_VOLT_CTRL) begin
      rdata_next[`BIT_LOW_VOLTAGE_ENABLE] = low_voltage_enable_reg;
      rdata_next[6] = lowv_s_reg;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      RDATA_OUT <= `RST_BYTE;
    end else begin
      RDATA_OUT <= RD_IN ? rdata_next : `RST_BYTE;
    end
  end

endmodule

// file: tb/pin_irq_wakeup_sva.sv
// Purpose: port-level checks of the pin and low-voltage interrupt block
// Assumes: enable registers are shadowed here from the write strobe port
// Notes: bound to every instance of pin_irq_wakeup
`include "pin_irq_consts.svh"
module pin_irq_wakeup_sva (
  // clock, reset and register port
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RDATA_OUT,
  // pins and core side
  input wire logic STD_EXT_INPUT_A_IN,
  input wire logic STD_EXT_INPUT_B_IN,
  input wire logic [7:0] EXTRA_EXT_INPUTS_IN,
  input wire logic [1:0] SERVICE_ACK_IN,
  input wire logic STD_A_REQ_OUT,
  input wire logic EXTRA_REQ_OUT,
  input wire logic LOW_VOLTAGE_REQ_OUT,
  input wire logic STOP_BLOCK_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RESETN_IN);
  logic [7:0] main_en_reg, e1_reg, ex_reg, tc_reg, lv_reg;
  // shadow copies update on the write edge, as the block's own registers do
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      {main_en_reg, e1_reg, ex_reg, tc_reg, lv_reg} <= '0;
    end else if (WR_IN) begin
      case (ADDR_IN)
        `OFS_INT_ENABLE_MAIN: main_en_reg <= WDATA_IN;
        `OFS_INT_ENABLE_EXTRA: e1_reg <= WDATA_IN;
        `OFS_EXT_ENABLE_GROUP: ex_reg <= WDATA_IN;
        `OFS_TIMER_EXT_CTRL: tc_reg <= WDATA_IN;
        `OFS_LOW_VOLT_CTRL: lv_reg <= WDATA_IN;
        default: ;
      endcase
    end
  end
  // an enabled input held low; sampling lag is covered by the depth of the checks
  wire logic low_en = (!STD_EXT_INPUT_A_IN && main_en_reg[0])
    || (!STD_EXT_INPUT_B_IN && main_en_reg[2])
    || (e1_reg[2] && |(~EXTRA_EXT_INPUTS_IN & ex_reg));
  chk_std_level_req:
    assert property ((main_en_reg[7] && main_en_reg[0] && !tc_reg[0] && !STD_EXT_INPUT_A_IN) [*3]
      |=> STD_A_REQ_OUT) else $error("level request missing");
  chk_ack_clears_a:
    assert property (SERVICE_ACK_IN == 2'b01 && $past(STD_EXT_INPUT_A_IN, 2)
      && $past(STD_EXT_INPUT_A_IN) && STD_EXT_INPUT_A_IN |-> ##2 !STD_A_REQ_OUT)
      else $error("request a kept after service");
  chk_extra_gated:
    assert property (EXTRA_REQ_OUT |-> $past(main_en_reg[7] && e1_reg[2] && ex_reg != 8'h00))
      else $error("extra request without enables");
  chk_lowvolt_gated:
    assert property (LOW_VOLTAGE_REQ_OUT |-> $past(main_en_reg[7] && e1_reg[2] && lv_reg[7]))
      else $error("low-voltage request without enables");
  chk_stop_has_cause:
    assert property (STOP_BLOCK_OUT |-> $past(low_en) || $past(low_en, 2) || $past(low_en, 3)
      || $past(low_en, 4)) else $error("stop refused with no enabled low input");
  chk_stop_when_low:
    assert property (low_en [*4] |=> STOP_BLOCK_OUT) else $error("stop not refused");
  chk_flags_reserved:
    assert property (RD_IN && ADDR_IN == `OFS_SHARED_FLAGS |=> (RDATA_OUT & ~`MASK_SHARED_FLAGS)
      == 8'h00) else $error("shared flags reserved bits set");
  chk_wake_en_readback:
    assert property ((WR_IN && ADDR_IN == `OFS_PORT_WAKE_EN) ##2 (RD_IN && ADDR_IN ==
      `OFS_PORT_WAKE_EN) |=> RDATA_OUT == $past(WDATA_IN, 3)) else $error("wake enable lost");
endmodule
bind pin_irq_wakeup pin_irq_wakeup_sva chk (.*);

// file: tb/pin_irq_wakeup_test.sv
// Purpose: directed register and pin tests of the pin interrupt block
// Assumes: steps are {op, x, y}: 1 write, 2 read, 3 wait x then outputs, 4 ack, 5 end, 8+ pins
// Notes: outs packs stop, wake, low-voltage, port, extra, b and a requests
module pin_irq_wakeup_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, ex, port, outs, x, y;
  logic [1:0] ack = 2'b00;
  logic [3:0] op;
  logic a, b, lv, ra, rb, rx, rp, rl, wake, stop;
  int miscompares = 0;
  int tests_run = 0;
  assign outs = {1'b0, stop, wake, rl, rp, rx, rb, ra};
  // system clock, 25 ns
  always #12.5 clk = ~clk;
  pin_model pins (.clk_in(clk), .a_out(a), .b_out(b), .ex_out(ex), .port_out(port),
    .lv_out(lv));
  pin_irq_wakeup dut (.CLK_SYS_IN(clk), .RESETN_IN(resetn), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .STD_EXT_INPUT_A_IN(a), .STD_EXT_INPUT_B_IN(b),
    .EXTRA_EXT_INPUTS_IN(ex), .PORT_PINS_IN(port), .LOW_VOLTAGE_DETECT_IN(lv),
    .SERVICE_ACK_IN(ack), .STD_A_REQ_OUT(ra), .STD_B_REQ_OUT(rb), .EXTRA_REQ_OUT(rx),
    .PORT_CHANGE_REQ_OUT(rp), .LOW_VOLTAGE_REQ_OUT(rl), .WAKE_OUT(wake), .STOP_BLOCK_OUT(stop));
  logic [19:0] steps[] = '{
    20'h28400, 20'h28500, 20'h28800, 20'h29600, 20'h2a800, 20'h2a900, 20'h20000,
    20'h1a8ff, 20'h2a8bf, 20'h196a5, 20'h296a5, 20'h1a800, 20'h50100,
    20'hefe00, 20'h30400, 20'h28501, 20'h18401, 20'h1a904, 20'h30260,
    20'h1a880, 20'h30264, 20'h40001, 20'heff00, 20'h30424, 20'h185fe, 20'h30200,
    20'hefd00, 20'h30400, 20'h28502, 20'h18500, 20'heff00, 20'h30400, 20'h28500,
    20'h50200, 20'h18801, 20'h1a881, 20'haff00, 20'h30461, 20'h28803,
    20'heff00, 20'h30421, 20'h40001, 20'h30200, 20'h28801, 20'h18800,
    20'haff00, 20'h30461, 20'h40001, 20'heff00, 20'h30400, 20'h1a880,
    20'haff00, 20'h30400, 20'heff00, 20'h18804, 20'h1a804, 20'hcff00, 20'h30460,
    20'h2880c, 20'heff00, 20'h40002, 20'h30200, 20'h50300,
    20'h1a880, 20'h19608, 20'heff08, 20'h30420, 20'h29502,
    20'h1a906, 20'h30228, 20'h40003, 20'h30200, 20'h29500,
    20'heff00, 20'h30428, 20'h195ff, 20'h29502, 20'h195fd, 20'h29500,
    20'heff10, 20'h30400, 20'h50400, 20'h1bf80, 20'hfff10, 20'h30410, 20'h29580,
    20'h1a902, 20'h30200, 20'heff10, 20'h30400, 20'h1957f, 20'h29500, 20'h50500};
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a_, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a_, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a_, input logic [7:0] exp);
    @(posedge clk);
    {rd, addr} <= {1'b1, a_};
    @(posedge clk);
    rd <= 1'b0;
    #1 check($sformatf("register %h", a_), exp, rdata);
  endtask
  task automatic outs_after(input logic [7:0] n, input logic [7:0] exp);
    repeat (n) @(posedge clk);
    #1 check("outputs", exp, outs);
  endtask
  task automatic ack_pulse(input logic [1:0] c);
    @(posedge clk);
    ack <= c;
    @(posedge clk);
    ack <= 2'b00;
  endtask
  task print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // reset for three cycles, then run the step table
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    foreach (steps[i]) begin
      {op, x, y} = steps[i];
      case (op)
        4'h1: wr_reg(x, y);
        4'h2: rd_reg(x, y);
        4'h3: outs_after(x, y);
        4'h4: ack_pulse(y[1:0]);
        4'h5: $display("test %0d done", x);
        default: pins.drive(op[2], op[1], x, y, op[0]);
      endcase
    end
    print_verdict();
  end
  // the table takes well under 1000 cycles; the limit at twice that means a hang
  initial begin
    #50us;
    miscompares++;
    print_verdict();
  end
endmodule

// file: tb/pin_model.sv
// Purpose: external interrupt pins, port pins and supply detector around the block
// Assumes: levels move just after a rising clock edge
// Notes: interrupt pins idle high as if pulled up
module pin_model (
  // clock
  input wire logic clk_in,
  // pins
  output logic a_out,
  output logic b_out,
  output logic [7:0] ex_out,
  output logic [7:0] port_out,
  output logic lv_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels from time zero, so reset sees no edges
  initial begin
    {a_out, b_out, ex_out, port_out, lv_out} = {1'b1, 1'b1, 8'hff, 8'h00, 1'b0};
  end
  // levels are held for several clocks so no transition is shorter than a sample
  task automatic drive(input logic a, input logic b, input logic [7:0] ex, input logic [7:0] p,
    input logic lv);
    @(posedge clk_in);
    {a_out, b_out, ex_out, port_out, lv_out} <= {a, b, ex, p, lv};
  endtask
endmodule
